// ===== pkg/aof_defines.svh
`ifndef AOF_DEFINES_SVH
`define AOF_DEFINES_SVH

// register addresses (7-bit serial port address space)
`define AOF_ADDR_PLL_EN1 7'h59
`define AOF_ADDR_CAP2 7'h5D
`define AOF_ADDR_PLL_EN2 7'h5F
`define AOF_ADDR_FMT 7'h62
`define AOF_ADDR_RES 7'h63
`define AOF_ADDR_PHASE 7'h64
`define AOF_ADDR_PAT_A_LO 7'h74
`define AOF_ADDR_PAT_A_HI 7'h75
`define AOF_ADDR_PAT_B_LO 7'h76
`define AOF_ADDR_PAT_B_HI 7'h77
`define AOF_ADDR_POSTPROC 7'h81

// reset values
`define AOF_RST_PLL_EN1 8'h41
`define AOF_RST_CAP2 8'h27
`define AOF_RST_PLL_EN2 8'hF1
`define AOF_RST_FMT 8'h10
`define AOF_RST_RES 8'h01
`define AOF_RST_PHASE 8'h03
`define AOF_RST_ZERO 8'h00
`define AOF_RST_LFSR 16'hACE1

// writable masks, unimplemented bits read as zero
`define AOF_MASK_TOP_UNUSED 8'h7F
`define AOF_MASK_FULL 8'hFF
`define AOF_MASK_POSTPROC 8'h01

// field positions
`define AOF_PLL_MAIN_BIT 1
`define AOF_PLL_OUT_BIT 3
`define AOF_PLL_BIAS_BIT 2
`define AOF_STREAM_BIT 6
`define AOF_FORMAT_BIT 5
`define AOF_MODE_HI 4
`define AOF_MODE_LO 3
`define AOF_PAT_HI 2
`define AOF_PAT_LO 0
`define AOF_NBITS_HI 7
`define AOF_NBITS_LO 4
`define AOF_LOAD_BIT 3
`define AOF_IMODE_HI 2
`define AOF_IMODE_LO 0
`define AOF_PHEN_BIT 7
`define AOF_PHSEL_HI 6
`define AOF_PHSEL_LO 4
`define AOF_CAP_HI 4
`define AOF_CAP_LO 0
`define AOF_POSTPROC_BIT 0

// ramp step dividers, decimation threshold and lfsr taps
`define AOF_RAMP_DIV_16 5'h03
`define AOF_RAMP_DIV_14 5'h0F
`define AOF_RAMP_DIV_1 5'h00
`define AOF_DECIM_MIN 4'h2
`define AOF_LFSR_TAPS 16'hB400

`endif

// ===== pkg/aof_pkg.sv
package aof_pkg;

   typedef enum logic [1:0] {
      AOF_OUT_OFF,
      AOF_OUT_CMOS,
      AOF_OUT_LVDS_EVEN,
      AOF_OUT_LVDS_BYTE
   } aof_mode_t;

   typedef enum logic [2:0] {
      AOF_PAT_NORMAL,
      AOF_PAT_CUSTOM,
      AOF_PAT_RAMP,
      AOF_PAT_CHECKER,
      AOF_PAT_ONES,
      AOF_PAT_ALT_LVDS,
      AOF_PAT_SYNC,
      AOF_PAT_PRBS
   } aof_pattern_t;

   // one output word and the side pins that travel with it
   typedef struct packed {
      logic [15:0] data;
      logic overrange;
      logic frame;
      logic extra_one;
      logic extra_two;
   } aof_word_t;

   typedef logic [7:0][15:0] aof_octal_t;

endpackage : aof_pkg

// ===== rtl/aof_output_format.sv
`timescale 1ns/1ns
`include "aof_defines.svh"
// What this block does
// RULE1: pll output drives only when output, bias and main pll enables all set
// RULE2: second loop capacitor select is five bits, resets to 00111
// RULE3: format bit set gives offset binary, clear gives two's complement
// RULE4: mode 11 byte ddr, 10 even-bit ddr, 01 cmos, 00 off
// RULE5: byte ddr mode puts bits 15..8 on rise, 7..0 on fall
// RULE6: even-bit ddr puts even bits on rise, odd bits on fall
// RULE7: stream type bit picks serialized or interleaved octal stream
// RULE8: serialized octal: one channel per pair, first channel on highest pair
// RULE9: serialized octal works only while octal post-processing is enabled
// RULE10: interleaved octal sends channels one after another in order
// RULE11: pattern 000 gives adc data, 111 gives lfsr pseudo-random data
// RULE12: pattern 110 gives eight ones then zeros, truncated to resolution
// RULE13: pattern 101 gives 01010101 10101010, truncated to resolution
// RULE14: cmos patterns 100 ones/zeros and 011 checker alternate each word
// RULE15: pattern 010 ramps one step per 4 words at 16 bits, 16 at 14
// RULE16: pattern 001 alternates words a and b, also on side pins
// RULE17: bit count field codes 1..15 select width, 0 means 16 bits
// RULE18: load bit enables internal lvds termination
// RULE19: software uses only drive currents 111, 011, 001, 000
// RULE20: phase delay select has no effect unless its enable is set
// RULE21: phase select shifts output clock by 45 degrees per step
// RULE22: phase delay only when decimation exceeds 2, odd steps on default filter
// RULE23: custom word a is built from low and high byte registers
// RULE24: software keeps unused low custom bits zero
// RULE25: pseudo-random generator uses a fixed maximal polynomial and seed
module aof_output_format
   import aof_pkg::*;
(
   input wire logic core_clk, // sample clock, 20 MHz
   input wire logic reset, // synchronous, active high
   input wire logic sclk_pin, // serial port clock
   input wire logic cs_pin_n, // serial port select, active low
   input wire logic sdi_pin, // serial port data in
   output logic sdo_out, // serial port data out
   output logic sdo_oe_n, // low while sdo driven
   input wire logic [15:0] adc_sample, // two's complement sample
   input wire logic adc_overrange, // overrange from the core
   input wire logic octal_mode, // eight-channel operation
   input wire aof_octal_t octal_samples, // channel samples, index 0 first
   input wire logic [3:0] decim_ratio, // decimation setting
   input wire logic decim_filter_a_default, // filter settings at default
   output logic [7:0] lvds_q, // lvds data pairs
   output logic lvds_dclk, // ddr output clock
   output logic [15:0] cmos_data, // cmos data bus
   output logic overrange_pin, // overrange pin
   output logic frame_clock_pin, // frame clock pin
   output logic extra_data_pin_one, // extra data pin one
   output logic extra_data_pin_two, // extra data pin two
   output logic lvds_term_en, // internal termination enable
   output logic [2:0] drive_current_sel, // lvds drive current code
   output logic pll_out_en, // pll output enabled
   output logic [4:0] loop_cap_second_sel, // loop filter cap two
   output logic [2:0] decim_clock_phase_sel, // applied 45 degree steps
   output logic phase_shift_active // phase delay in use
);
   logic [7:0] pll_en1_reg, cap2_reg, pll_en2_reg, fmt_reg, res_reg, phase_reg;
   logic [7:0] pat_a_lo_reg, pat_a_hi_reg, pat_b_lo_reg, pat_b_hi_reg, postproc_reg;
   logic [6:0] spi_addr;
   logic [7:0] spi_wdata, rd_data;
   logic spi_wr;
   logic half_reg, alt_reg;
   logic [2:0] chan_reg;
   logic [4:0] ramp_div_reg;
   logic [15:0] ramp_reg, lfsr_reg, lfsr_next, pat_a, pat_b, sample_fmt, res_mask;
   aof_word_t word_reg, word_next;
   logic [7:0][15:0] ser_reg;
   logic [7:0] rise_bits, fall_bits, ser_bits;
   aof_mode_t mode;
   aof_pattern_t pattern;
   logic [4:0] nbits;
   logic serial_on, load_en;

   aof_serial_port u_port (
      .core_clk(core_clk),
      .reset(reset),
      .sclk_pin(sclk_pin),
      .cs_pin_n(cs_pin_n),
      .sdi_pin(sdi_pin),
      .rd_data(rd_data),
      .sdo_out(sdo_out),
      .sdo_oe_n(sdo_oe_n),
      .addr(spi_addr),
      .wr_data(spi_wdata),
      .wr_pulse(spi_wr)
   );

   // number of output bits for a field code
   function automatic logic [4:0] width_of(input logic [3:0] code);
      width_of = (code == 4'h0) ? 5'h10 : {1'b0, code}; // RULE17
   endfunction : width_of

   // keeps the top n bits of the data word; with pattern 001 low bits 1 and 0 still leave on the extra data pins
   function automatic logic [15:0] top_mask(input logic [4:0] n);
      top_mask = ~(16'hFFFF >> n);
   endfunction : top_mask

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pll_en1_reg <= `AOF_RST_PLL_EN1;
         cap2_reg <= `AOF_RST_CAP2; // RULE2
         pll_en2_reg <= `AOF_RST_PLL_EN2;
         fmt_reg <= `AOF_RST_FMT;
         res_reg <= `AOF_RST_RES;
         phase_reg <= `AOF_RST_PHASE;
         pat_a_lo_reg <= `AOF_RST_ZERO;
         pat_a_hi_reg <= `AOF_RST_ZERO;
         pat_b_lo_reg <= `AOF_RST_ZERO;
         pat_b_hi_reg <= `AOF_RST_ZERO;
         postproc_reg <= `AOF_RST_ZERO;
      end else if (spi_wr) begin
         if (spi_addr == `AOF_ADDR_PLL_EN1) begin
            pll_en1_reg <= spi_wdata & `AOF_MASK_TOP_UNUSED;
         end else if (spi_addr == `AOF_ADDR_CAP2) begin
            cap2_reg <= spi_wdata & `AOF_MASK_TOP_UNUSED; // RULE2
         end else if (spi_addr == `AOF_ADDR_PLL_EN2) begin
            pll_en2_reg <= spi_wdata;
         end else if (spi_addr == `AOF_ADDR_FMT) begin
            fmt_reg <= spi_wdata & `AOF_MASK_TOP_UNUSED;
         end else if (spi_addr == `AOF_ADDR_RES) begin
            res_reg <= spi_wdata; // RULE19
         end else if (spi_addr == `AOF_ADDR_PHASE) begin
            phase_reg <= spi_wdata;
         end else if (spi_addr == `AOF_ADDR_PAT_A_LO) begin
            pat_a_lo_reg <= spi_wdata; // RULE24
         end else if (spi_addr == `AOF_ADDR_PAT_A_HI) begin
            pat_a_hi_reg <= spi_wdata;
         end else if (spi_addr == `AOF_ADDR_PAT_B_LO) begin
            pat_b_lo_reg <= spi_wdata;
         end else if (spi_addr == `AOF_ADDR_PAT_B_HI) begin
            pat_b_hi_reg <= spi_wdata;
         end else if (spi_addr == `AOF_ADDR_POSTPROC) begin
            postproc_reg <= spi_wdata & `AOF_MASK_POSTPROC;
         end
      end
   end

   // unmapped addresses read as zero
   always_comb begin
      if (spi_addr == `AOF_ADDR_PLL_EN1) begin
         rd_data = pll_en1_reg;
      end else if (spi_addr == `AOF_ADDR_CAP2) begin
         rd_data = cap2_reg;
      end else if (spi_addr == `AOF_ADDR_PLL_EN2) begin
         rd_data = pll_en2_reg;
      end else if (spi_addr == `AOF_ADDR_FMT) begin
         rd_data = fmt_reg;
      end else if (spi_addr == `AOF_ADDR_RES) begin
         rd_data = res_reg;
      end else if (spi_addr == `AOF_ADDR_PHASE) begin
         rd_data = phase_reg;
      end else if (spi_addr == `AOF_ADDR_PAT_A_LO) begin
         rd_data = pat_a_lo_reg;
      end else if (spi_addr == `AOF_ADDR_PAT_A_HI) begin
         rd_data = pat_a_hi_reg;
      end else if (spi_addr == `AOF_ADDR_PAT_B_LO) begin
         rd_data = pat_b_lo_reg;
      end else if (spi_addr == `AOF_ADDR_PAT_B_HI) begin
         rd_data = pat_b_hi_reg;
      end else if (spi_addr == `AOF_ADDR_POSTPROC) begin
         rd_data = postproc_reg;
      end else begin
         rd_data = 8'h00;
      end
   end

   assign mode = aof_mode_t'(fmt_reg[`AOF_MODE_HI:`AOF_MODE_LO]);
   assign pattern = aof_pattern_t'(fmt_reg[`AOF_PAT_HI:`AOF_PAT_LO]);
   assign nbits = width_of(res_reg[`AOF_NBITS_HI:`AOF_NBITS_LO]);
   assign res_mask = top_mask(nbits); // RULE12 RULE13
   assign pat_a = {pat_a_hi_reg, pat_a_lo_reg}; // RULE23
   assign pat_b = {pat_b_hi_reg, pat_b_lo_reg};
   // serial octal needs 16 bits, the octal bit and post-processing enable
   assign serial_on = octal_mode && fmt_reg[`AOF_STREAM_BIT] && postproc_reg[`AOF_POSTPROC_BIT]
      && nbits == 5'h10; // RULE7 RULE8 RULE9
   // a new word is taken at the end of each rising half
   assign load_en = half_reg;

   // one core cycle per ddr half, so the output clock runs at half the core rate
   always_ff @(posedge core_clk) begin
      if (reset) begin
         half_reg <= 1'b0;
      end else begin
         half_reg <= ~half_reg;
      end
   end

   // galois lfsr, taps for x^16+x^14+x^13+x^11+1, never stuck at zero from this seed
   assign lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `AOF_LFSR_TAPS) : (lfsr_reg >> 1);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         lfsr_reg <= `AOF_RST_LFSR; // RULE25
         alt_reg <= 1'b0;
         chan_reg <= 3'h0;
      end else if (load_en) begin
         lfsr_reg <= lfsr_next; // RULE11
         alt_reg <= ~alt_reg;
         chan_reg <= chan_reg + 3'h1; // RULE10
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || pattern != AOF_PAT_RAMP) begin
         ramp_reg <= 16'h0000;
         ramp_div_reg <= 5'h00;
      end else if (load_en) begin
         if (ramp_div_reg == ((nbits == 5'h10) ? `AOF_RAMP_DIV_16 :
               (nbits == 5'h0E) ? `AOF_RAMP_DIV_14 : `AOF_RAMP_DIV_1)) begin // RULE15
            ramp_div_reg <= 5'h00;
            ramp_reg <= ramp_reg + (16'h8000 >> (nbits - 5'h01));
         end else begin
            ramp_div_reg <= ramp_div_reg + 5'h01;
         end
      end
   end

   always_comb begin
      sample_fmt = octal_mode ? octal_samples[chan_reg] : adc_sample;
      if (fmt_reg[`AOF_FORMAT_BIT]) begin
         sample_fmt = {~sample_fmt[15], sample_fmt[14:0]}; // RULE3
      end
      word_next.overrange = adc_overrange;
      word_next.frame = octal_mode ? (chan_reg == 3'h0) : alt_reg;
      word_next.extra_one = 1'b0;
      word_next.extra_two = 1'b0;
      case (pattern)
         AOF_PAT_NORMAL: word_next.data = sample_fmt; // RULE11
         AOF_PAT_PRBS: word_next.data = lfsr_reg; // RULE11
         AOF_PAT_SYNC: word_next.data = 16'hFF00; // RULE12
         AOF_PAT_ALT_LVDS: word_next.data = 16'h55AA; // RULE13
         AOF_PAT_ONES: word_next.data = alt_reg ? 16'h0000 : 16'hFFFF; // RULE14
         AOF_PAT_CHECKER: word_next.data = alt_reg ? 16'hAAAA : 16'h5555; // RULE14
         AOF_PAT_RAMP: word_next.data = ramp_reg; // RULE15
         default: begin
            // a in even words, b in odd words, side pins follow the word
            word_next.data = alt_reg ? pat_b : pat_a; // RULE16
            word_next.overrange = word_next.data[15]; // RULE16
            word_next.frame = word_next.data[14];
            word_next.extra_one = word_next.data[1];
            word_next.extra_two = word_next.data[0];
         end
      endcase
      word_next.data = word_next.data & res_mask; // RULE17
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         word_reg <= '0;
      end else if (load_en) begin
         word_reg <= word_next;
      end
   end

   // each pair shifts its channel out msb first, two bits per output clock
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ser_reg <= '0;
      end else if (load_en && chan_reg == 3'h7) begin
         for (int p = 0; p < 8; p++) begin
            ser_reg[p] <= octal_samples[7 - p] ^ {fmt_reg[`AOF_FORMAT_BIT], 15'h0000}; // RULE8
         end
      end else begin
         for (int p = 0; p < 8; p++) begin
            ser_reg[p] <= {ser_reg[p][14:0], 1'b0};
         end
      end
   end

   generate
      for (genvar i = 0; i < 8; i++) begin : g_pair
         assign rise_bits[i] = (mode == AOF_OUT_LVDS_BYTE) ? word_reg.data[i + 8] :
            word_reg.data[2 * i]; // RULE5 RULE6
         assign fall_bits[i] = (mode == AOF_OUT_LVDS_BYTE) ? word_reg.data[i] :
            word_reg.data[2 * i + 1]; // RULE5 RULE6
         assign ser_bits[i] = ser_reg[i][15];
      end
   endgenerate

   // all pins rest low while outputs are disabled
   always_ff @(posedge core_clk) begin
      if (reset || mode == AOF_OUT_OFF) begin // RULE4
         lvds_q <= 8'h00;
         lvds_dclk <= 1'b0;
         cmos_data <= 16'h0000;
         overrange_pin <= 1'b0;
         frame_clock_pin <= 1'b0;
         extra_data_pin_one <= 1'b0;
         extra_data_pin_two <= 1'b0;
      end else begin
         extra_data_pin_one <= word_reg.extra_one;
         extra_data_pin_two <= word_reg.extra_two;
         overrange_pin <= word_reg.overrange;
         if (mode == AOF_OUT_CMOS) begin // RULE4
            cmos_data <= word_reg.data;
            lvds_q <= 8'h00;
            lvds_dclk <= ~half_reg;
            frame_clock_pin <= word_reg.frame;
         end else begin
            cmos_data <= 16'h0000;
            lvds_dclk <= ~half_reg;
            if (serial_on && pattern == AOF_PAT_NORMAL) begin
               lvds_q <= ser_bits; // RULE8
               frame_clock_pin <= chan_reg[2] == 1'b0;
            end else begin
               lvds_q <= half_reg ? fall_bits : rise_bits; // RULE5 RULE6
               frame_clock_pin <= word_reg.frame;
            end
         end
      end
   end

   // analog-side controls
   always_ff @(posedge core_clk) begin
      if (reset) begin
         lvds_term_en <= 1'b0;
         drive_current_sel <= 3'h1;
         pll_out_en <= 1'b0;
         loop_cap_second_sel <= 5'h07;
         decim_clock_phase_sel <= 3'h0;
         phase_shift_active <= 1'b0;
      end else begin
         lvds_term_en <= res_reg[`AOF_LOAD_BIT]; // RULE18
         drive_current_sel <= res_reg[`AOF_IMODE_HI:`AOF_IMODE_LO];
         pll_out_en <= pll_en2_reg[`AOF_PLL_OUT_BIT] && pll_en2_reg[`AOF_PLL_BIAS_BIT]
            && pll_en1_reg[`AOF_PLL_MAIN_BIT]; // RULE1
         loop_cap_second_sel <= cap2_reg[`AOF_CAP_HI:`AOF_CAP_LO]; // RULE2
         // phase stays at the reference step unless enabled and decimating above 2
         if (phase_reg[`AOF_PHEN_BIT] && decim_ratio > `AOF_DECIM_MIN) begin // RULE20 RULE22
            phase_shift_active <= 1'b1;
            decim_clock_phase_sel <= {phase_reg[`AOF_PHSEL_HI:`AOF_PHSEL_LO + 1],
               phase_reg[`AOF_PHSEL_LO] | decim_filter_a_default}; // RULE21 RULE22
         end else begin
            phase_shift_active <= 1'b0;
            decim_clock_phase_sel <= 3'h0;
         end
      end
   end
endmodule : aof_output_format

// ===== rtl/aof_serial_port.sv
`timescale 1ns/1ns
`include "aof_defines.svh"
// 16-bit frame: read flag, 7 address bits, 8 data bits, msb first on rising sclk
module aof_serial_port
   import aof_pkg::*;
(
   input wire logic core_clk, // system clock
   input wire logic reset, // synchronous, active high
   input wire logic sclk_pin, // serial clock, asynchronous
   input wire logic cs_pin_n, // chip select, active low
   input wire logic sdi_pin, // serial data in
   input wire logic [7:0] rd_data, // read data for addr
   output logic sdo_out, // serial data out
   output logic sdo_oe_n, // low while driving sdo
   output logic [6:0] addr, // frame address
   output logic [7:0] wr_data, // write data
   output logic wr_pulse // one-cycle write strobe
);
   logic [2:0] sclk_sync_reg, cs_sync_reg;
   logic [1:0] sdi_sync_reg;
   logic [15:0] shift_reg;
   logic [4:0] count_reg;
   logic [7:0] out_reg;
   logic sclk_rise, sclk_fall, cs_active;

   // two stages before any logic; third stage only for edge finding
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sclk_sync_reg <= 3'h0;
         cs_sync_reg <= 3'h7;
         sdi_sync_reg <= 2'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
         cs_sync_reg <= {cs_sync_reg[1:0], cs_pin_n};
         sdi_sync_reg <= {sdi_sync_reg[0], sdi_pin};
      end
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   assign cs_active = ~cs_sync_reg[1];
   assign addr = (count_reg == 5'h10) ? shift_reg[14:8] : shift_reg[6:0];
   assign wr_data = shift_reg[7:0];

   always_ff @(posedge core_clk) begin
      if (reset || !cs_active) begin
         shift_reg <= 16'h0000;
         count_reg <= 5'h00;
         wr_pulse <= 1'b0;
      end else begin
         wr_pulse <= 1'b0;
         if (sclk_rise && count_reg != 5'h10) begin
            shift_reg <= {shift_reg[14:0], sdi_sync_reg[1]};
            count_reg <= count_reg + 5'h01;
            if (count_reg == 5'h0F && !shift_reg[14]) begin
               wr_pulse <= 1'b1;
            end
         end
      end
   end

   // read data is captured once the address is complete, then shifted on falling sclk
   always_ff @(posedge core_clk) begin
      if (reset || !cs_active) begin
         out_reg <= 8'h00;
         sdo_out <= 1'b0;
         sdo_oe_n <= 1'b1;
      end else if (count_reg == 5'h08 && shift_reg[7] && sdo_oe_n) begin
         out_reg <= {rd_data[6:0], 1'b0};
         sdo_out <= rd_data[7];
         sdo_oe_n <= 1'b0;
      end else if (sclk_fall && !sdo_oe_n) begin
         out_reg <= {out_reg[6:0], 1'b0};
         sdo_out <= out_reg[7];
      end
   end
endmodule : aof_serial_port

// ===== verif/aof_capture_model.sv
`timescale 1ns/1ns
module aof_capture_model
   import aof_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic reset, // sync reset
   input wire logic [7:0] lvds_q, // data pairs
   input wire logic lvds_dclk, // ddr clock
   input wire logic byte_first, // high byte mode
   output logic [15:0] word_reg, // rebuilt word
   output logic valid_reg // word strobe
);
   logic [7:0] rise_reg;
   logic dclk_reg;
   logic [15:0] even_word;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         even_word[2*i] = rise_reg[i];
         even_word[2*i+1] = lvds_q[i];
      end
   end
   // sampled on the core clock: dclk is its register, so no skew to absorb
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rise_reg <= 8'h00;
         dclk_reg <= 1'b0;
         valid_reg <= 1'b0;
         word_reg <= 16'h0000;
      end else begin
         dclk_reg <= lvds_dclk;
         valid_reg <= dclk_reg && !lvds_dclk;
         if (lvds_dclk) rise_reg <= lvds_q;
         if (dclk_reg && !lvds_dclk) word_reg <= byte_first ? {rise_reg, lvds_q} : even_word;
      end
   end
endmodule : aof_capture_model

// ===== verif/aof_output_format_monitor.sv
`timescale 1ns/1ns
module aof_output_format_monitor
   import aof_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic reset, // sync reset
   input wire logic cs_pin_n, // select
   input wire logic [3:0] decim_ratio, // decimation
   input wire logic decim_filter_a_default, // default filter
   input wire logic lvds_dclk, // ddr clock
   input wire logic pll_out_en, // pll out
   input wire logic [4:0] loop_cap_second_sel, // cap two
   input wire logic lvds_term_en, // termination
   input wire logic [2:0] drive_current_sel, // drive code
   input wire logic [2:0] decim_clock_phase_sel, // phase
   input wire logic phase_shift_active // phase in use
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // eight idle cycles cover the write landing after the last serial bit
   sequence s_cs_idle;
      cs_pin_n [*8];
   endsequence
   sequence s_low_decim;
      (decim_ratio <= 4'h2) [*3];
   endsequence
   a_reset_values: assert property (
      $fell(reset) |-> loop_cap_second_sel == 5'h07 && drive_current_sel == 3'h1
         && !pll_out_en && !lvds_term_en) else $error("bad value after reset");
   a_ddr_half: assert property (lvds_dclk |=> !lvds_dclk)
      else $error("ddr clock high two cycles");
   a_drive_legal: assert property (
      drive_current_sel inside {3'h7, 3'h3, 3'h1, 3'h0}) else $error("drive code illegal");
   a_low_decim: assert property (s_low_decim |-> !phase_shift_active)
      else $error("phase delay with low decimation");
   a_odd_steps: assert property (
      decim_filter_a_default [*3] ##0 phase_shift_active |-> decim_clock_phase_sel[0])
      else $error("even phase step on default filter");
   a_cap_holds: assert property (s_cs_idle |-> $stable(loop_cap_second_sel))
      else $error("cap select moved without access");
   a_term_holds: assert property (s_cs_idle |-> $stable(lvds_term_en))
      else $error("termination moved without access");
   a_pll_holds: assert property (s_cs_idle |-> $stable(pll_out_en))
      else $error("pll output moved without access");
endmodule : aof_output_format_monitor

bind aof_output_format aof_output_format_monitor i_mon (.core_clk, .reset, .cs_pin_n,
   .decim_ratio, .decim_filter_a_default, .lvds_dclk, .pll_out_en, .loop_cap_second_sel,
   .lvds_term_en, .drive_current_sel, .decim_clock_phase_sel, .phase_shift_active);

// ===== verif/aof_output_format_tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module aof_output_format_tb_top;
   typedef struct packed {logic [6:0] a; logic [7:0] w; logic [7:0] r; logic we;} aof_row_t;
   logic core_clk = 1'b0, reset = 1'b1, sclk_pin = 1'b0, cs_pin_n = 1'b1, sdi_pin = 1'b0;
   logic decim_filter_a_default = 1'b1, byte_first = 1'b1;
   logic sdo_out, sdo_oe_n, lvds_dclk, overrange_pin, extra_data_pin_two, lvds_term_en;
   logic pll_out_en, phase_shift_active, valid_reg, frame_clock_pin, extra_data_pin_one;
   logic [15:0] adc_sample = 16'h1234, cmos_data, word_reg, r0;
   logic [7:0] lvds_q, q;
   logic [3:0] decim_ratio = 4'h0;
   logic [4:0] loop_cap_second_sel;
   logic [2:0] drive_current_sel, decim_clock_phase_sel;
   int err_total = 0, n_compared = 0;
   aof_row_t rows [12] = '{'{7'h5D, 8'h00, 8'h27, 1'b0}, '{7'h5F, 8'h00, 8'hF1, 1'b0},
      '{7'h62, 8'h00, 8'h10, 1'b0}, '{7'h63, 8'h00, 8'h01, 1'b0}, '{7'h64, 8'h00, 8'h03, 1'b0},
      '{7'h5D, 8'hFF, 8'h7F, 1'b1}, '{7'h10, 8'h55, 8'h00, 1'b1}, '{7'h81, 8'hFF, 8'h01, 1'b1},
      '{7'h75, 8'hC3, 8'hC3, 1'b1}, '{7'h74, 8'hA5, 8'hA5, 1'b1}, '{7'h77, 8'h5A, 8'h5A, 1'b1},
      '{7'h76, 8'h3C, 8'h3C, 1'b1}};

   aof_output_format i_dut (.core_clk, .reset, .sclk_pin, .cs_pin_n, .sdi_pin, .sdo_out,
      .sdo_oe_n, .adc_sample, .adc_overrange(1'b0), .octal_mode(1'b0), .octal_samples('0),
      .decim_ratio, .decim_filter_a_default, .lvds_q, .lvds_dclk, .cmos_data, .overrange_pin,
      .frame_clock_pin, .extra_data_pin_one, .extra_data_pin_two, .lvds_term_en,
      .drive_current_sel, .pll_out_en, .loop_cap_second_sel, .decim_clock_phase_sel,
      .phase_shift_active);
   aof_capture_model i_cap (.core_clk, .reset, .lvds_q, .lvds_dclk, .byte_first, .word_reg,
      .valid_reg);

   initial forever #25 core_clk = ~core_clk;

   task summarize;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize

   // 400 ns serial clock; sdo is taken at the end of the high halves of frame bits 8 down to 1
   task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d);
      logic [15:0] f;
      f = {rd, a, d};
      cs_pin_n = 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = 15; i >= 0; i--) begin
         sdi_pin = f[i];
         repeat (4) @(negedge core_clk);
         sclk_pin = 1'b1;
         repeat (4) @(negedge core_clk);
         if (i inside {[1:8]}) q[i-1] = sdo_oe_n ? 1'bx : sdo_out;
         sclk_pin = 1'b0;
      end
      repeat (4) @(negedge core_clk);
      cs_pin_n = 1'b1;
      repeat (8) @(negedge core_clk);
   endtask : spi

   task automatic word_chk(input logic [7:0] cfg, input logic [15:0] e);
      int k;
      spi(1'b0, 7'h62, cfg);
      k = 0;
      while (valid_reg !== 1'b1 && k < 20) begin
         @(negedge core_clk);
         k++;
      end
      if (k == 20) begin
         err_total++;
         summarize();
      end
      `CHK("word", e, word_reg)
   endtask : word_chk

   task automatic alt(input logic [7:0] cfg, input logic [15:0] a, input logic [15:0] b);
      logic [15:0] x;
      logic [3:0] sd;
      spi(1'b0, 7'h62, cfg);
      x = cmos_data;
      sd = {overrange_pin, frame_clock_pin, extra_data_pin_one, extra_data_pin_two};
      repeat (2) @(negedge core_clk);
      `CHK("alt", a ^ b, x ^ cmos_data)
      `CHK("alt", 1'b1, x === a || x === b)
      if (cfg[2:0] == 3'b001) `CHK("side", {x[15:14], x[1:0]}, sd)
   endtask : alt

   initial begin
      repeat (6) @(negedge core_clk);
      reset = 1'b0;
      repeat (4) @(negedge core_clk);
      `CHK("rst", 10'h0E4, {loop_cap_second_sel, drive_current_sel, pll_out_en, lvds_term_en})
      foreach (rows[i]) begin
         if (rows[i].we) spi(1'b0, rows[i].a, rows[i].w);
         spi(1'b1, rows[i].a, 8'h00);
         `CHK("reg", rows[i].r, q)
      end
      `CHK("cap", 5'h1F, loop_cap_second_sel)
      spi(1'b0, 7'h5F, 8'hFD);
      `CHK("pll", 1'b0, pll_out_en)
      spi(1'b0, 7'h59, 8'h43);
      `CHK("pll", 1'b1, pll_out_en)
      spi(1'b0, 7'h63, 8'h08);
      `CHK("load", 4'h8, {lvds_term_en, drive_current_sel})
      word_chk(8'h18, 16'h1234);
      word_chk(8'h38, 16'h9234);
      word_chk(8'h1E, 16'hFF00);
      byte_first = 1'b0;
      word_chk(8'h15, 16'h55AA);
      alt(8'h0C, 16'hFFFF, 16'h0000);
      alt(8'h0B, 16'h5555, 16'hAAAA);
      alt(8'h09, 16'hC3A5, 16'h5A3C);
      spi(1'b0, 7'h62, 8'h0A);
      r0 = cmos_data;
      repeat (8) @(negedge core_clk);
      `CHK("ramp", r0 + 16'h0001, cmos_data)
      spi(1'b0, 7'h62, 8'h0F);
      r0 = cmos_data;
      repeat (2) @(negedge core_clk);
      `CHK("prbs", 1'b1, r0 !== cmos_data)
      spi(1'b0, 7'h62, 8'h0A);
      spi(1'b0, 7'h63, 8'hE8);
      r0 = cmos_data;
      repeat (32) @(negedge core_clk);
      `CHK("ramp", r0 + 16'h0004, cmos_data)
      spi(1'b0, 7'h62, 8'h00);
      `CHK("off", 25'h0, {lvds_q, lvds_dclk, cmos_data})
      decim_ratio = 4'h3;
      spi(1'b0, 7'h64, 8'hA3);
      `CHK("phase", 4'hB, {phase_shift_active, decim_clock_phase_sel})
      decim_filter_a_default = 1'b0;
      repeat (4) @(negedge core_clk);
      `CHK("phase", 4'hA, {phase_shift_active, decim_clock_phase_sel})
      decim_ratio = 4'h2;
      repeat (4) @(negedge core_clk);
      `CHK("act", 1'b0, phase_shift_active)
      decim_ratio = 4'h3;
      spi(1'b0, 7'h64, 8'h23);
      `CHK("act", 1'b0, phase_shift_active)
      summarize();
   end
endmodule : aof_output_format_tb_top
